/* File: verilog/dif_pkg.sv */
`default_nettype none

package dif_pkg;
	localparam int NUM_CFG_INPUTS = 8;
	localparam int NUM_GROUPS = 4;
	localparam int GROUP_SIZE = 2;
	localparam int GROUP_W = 2;
	localparam int MS_W = 4;
	localparam logic [MS_W-1:0] FILTER_OFF_MS = 4'h0;
	localparam logic [MS_W-1:0] FILTER_MIN_MS = 4'h3;
	localparam logic [MS_W-1:0] FILTER_MAX_MS = 4'hF;
	localparam logic [MS_W-1:0] DEFAULT_MS = 4'h3;
	localparam logic [MS_W-1:0] FIXED_MS = 4'h3;
	localparam logic [MS_W-1:0] REJECT_MARGIN_MS = 4'h2;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage

`default_nettype wire

/* File: verilog/dif_tick_div.sv */
`default_nettype none

module dif_tick_div #(
	parameter int CYCLES = 40000
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// one-cycle tick
	output logic tick
);
	localparam int CW = $clog2(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic tick;
	} dif_div_type;

	dif_div_type s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.count == LAST) begin
			s_d.count = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.count = s_q.count + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule

`default_nettype wire

/* File: verilog/dif_input_filter.sv */
`default_nettype none

module dif_input_filter import dif_pkg::*; #(
	parameter int NUM_INPUTS = 16,
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// field inputs, asynchronous
	input wire logic [NUM_INPUTS-1:0] rawIn,
	// configuration
	input wire logic cfgWrite,
	input wire logic [GROUP_W-1:0] cfgGroup,
	input wire logic [MS_W-1:0] cfgFilterMs,
	input wire logic cfgClear,
	input wire logic [NUM_GROUPS-1:0] groupNormal,
	// scan side
	input wire logic endOfScan,
	output logic [NUM_INPUTS-1:0] inputImage,
	output logic cfgError
);
	localparam int HI = NUM_INPUTS - 1;

	typedef logic [NUM_GROUPS-1:0][MS_W-1:0] dif_groups_type;

	typedef struct packed {
		logic [NUM_INPUTS-1:0] sync1;
		logic [NUM_INPUTS-1:0] sync2;
		logic [NUM_INPUTS-1:0] filt;
		logic [NUM_INPUTS-1:0] image;
		logic [NUM_INPUTS-1:0][MS_W-1:0] cnt;
		dif_groups_type groupMs;
		logic cfgError;
	} dif_state_type;

	localparam dif_state_type RESET_STATE = '{
		groupMs: {NUM_GROUPS{DEFAULT_MS}},
		default: '0
	};

	dif_state_type s_q, s_d;
	logic msTick;

	dif_tick_div #(
		.CYCLES(TICK_CYCLES_P)
	) u_tick (
		.clk(clk),
		.reset_n(reset_n),
		.tick(msTick)
	);

	// legal filter settings
	function automatic logic validMs(input logic [MS_W-1:0] v);
		return (v == FILTER_OFF_MS) ||
			((v >= FILTER_MIN_MS) && (v <= FILTER_MAX_MS));
	endfunction

	// filter time that applies to one input
	function automatic logic [MS_W-1:0] msOf(input int idx,
			input dif_groups_type gms);
		if (idx < NUM_CFG_INPUTS) begin
			return gms[idx / GROUP_SIZE];
		end
		return FIXED_MS;
	endfunction

	// input skips the counter
	function automatic logic bypassOf(input int idx,
			input dif_groups_type gms, input logic [NUM_GROUPS-1:0] nrm);
		if (idx < NUM_CFG_INPUTS) begin
			return !nrm[idx / GROUP_SIZE] ||
				(gms[idx / GROUP_SIZE] == FILTER_OFF_MS);
		end
		return 1'b0;
	endfunction

	// ticks needed: one below the setting keeps a full-width pulse safe
	function automatic logic [MS_W-1:0] thrOf(input logic [MS_W-1:0] ms);
		return ms - REJECT_MARGIN_MS + MS_W'(1);
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.sync1 = rawIn;
		s_d.sync2 = s_q.sync1;
		s_d.cfgError = 1'b0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (bypassOf(i, s_q.groupMs, groupNormal)) begin
				s_d.filt[i] = s_q.sync2[i];
				s_d.cnt[i] = '0;
			end else if (s_q.sync2[i] == s_q.filt[i]) begin
				s_d.cnt[i] = '0;
			end else if (msTick) begin
				if (s_q.cnt[i] + MS_W'(1) >=
						thrOf(msOf(i, s_q.groupMs))) begin
					s_d.filt[i] = s_q.sync2[i];
					s_d.cnt[i] = '0;
				end else begin
					s_d.cnt[i] = s_q.cnt[i] + MS_W'(1);
				end
			end
		end
		if (endOfScan) begin
			s_d.image = s_q.filt;
		end
		if (cfgClear) begin
			s_d.groupMs = RESET_STATE.groupMs;
		end else if (cfgWrite) begin
			if (validMs(cfgFilterMs)) begin
				s_d.groupMs[cfgGroup] = cfgFilterMs;
			end else begin
				s_d.cfgError = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= RESET_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	assign inputImage = s_q.image;
	assign cfgError = s_q.cfgError;

	// helper view of input 0
	logic [MS_W-1:0] thr0;
	logic byp0;
	logic [MS_W-1:0] nextCnt0;
	assign thr0 = thrOf(msOf(0, s_q.groupMs));
	assign byp0 = bypassOf(0, s_q.groupMs, groupNormal);
	assign nextCnt0 = s_q.cnt[0] + MS_W'(1);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_pending0;
		!byp0 && (s_q.sync2[0] != s_q.filt[0]) && msTick;
	endsequence

	sequence s_advance0;
		s_pending0 ##0 (nextCnt0 < thr0);
	endsequence

	sequence s_settle0;
		s_pending0 ##0 (nextCnt0 >= thr0);
	endsequence

	property p_image_hold;
		!endOfScan |=> $stable(inputImage);
	endproperty
	a_image_hold: assert property (p_image_hold)
		else $error("image changed outside end of scan");

	property p_image_load;
		endOfScan |=> inputImage == $past(s_q.filt);
	endproperty
	a_image_load: assert property (p_image_load)
		else $error("image not loaded from filtered state");

	property p_cfg_clear;
		cfgClear |=> s_q.groupMs == RESET_STATE.groupMs;
	endproperty
	a_cfg_clear: assert property (p_cfg_clear)
		else $error("clear did not restore default filter");

	property p_cfg_write;
		cfgWrite && !cfgClear && validMs(cfgFilterMs) |=>
			s_q.groupMs[$past(cfgGroup)] == $past(cfgFilterMs) &&
			!cfgError;
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("valid group setting not stored");

	property p_cfg_bad;
		cfgWrite && !cfgClear && !validMs(cfgFilterMs) |=>
			cfgError && $stable(s_q.groupMs);
	endproperty
	a_cfg_bad: assert property (p_cfg_bad)
		else $error("illegal filter setting accepted");

	property p_bypass;
		byp0 && groupNormal[0] |=> s_q.filt[0] == $past(s_q.sync2[0]);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("zero setting did not pass raw level");

	property p_special;
		!groupNormal[0] |=> s_q.cnt[0] == '0;
	endproperty
	a_special: assert property (p_special)
		else $error("special group used the filter counter");

	property p_count;
		s_advance0 |=> s_q.cnt[0] == $past(nextCnt0) &&
			$stable(s_q.filt[0]);
	endproperty
	a_count: assert property (p_count)
		else $error("stability counter did not advance");

	property p_pass;
		s_settle0 |=> s_q.filt[0] == $past(s_q.sync2[0]);
	endproperty
	a_pass: assert property (p_pass)
		else $error("held level did not pass the filter");

	property p_reject;
		$changed(s_q.filt[0]) && !$past(byp0) |->
			$past(msTick) && ($past(nextCnt0) >= $past(thr0));
	endproperty
	a_reject: assert property (p_reject)
		else $error("filtered state changed before count reached");

	property p_fixed;
		$changed(s_q.filt[HI]) |->
			$past(msTick) &&
			($past(s_q.cnt[HI]) == FIXED_MS - REJECT_MARGIN_MS);
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed filter input changed at wrong count");
endmodule

`default_nettype wire

/* File: verification/dif_noise_src.sv */
`default_nettype none

module dif_noise_src (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// glitch request
	input wire logic [15:0] level,
	input wire logic [15:0] pulseMask,
	input wire logic [15:0] pulseLen,
	input wire logic pulseGo,
	// field side
	output logic [15:0] rawIn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] left_q;
	// a glitch inverts the masked lines for pulseLen clocks
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			left_q <= 16'h0000;
		end else if (pulseGo) begin
			left_q <= pulseLen;
		end else if (left_q != 16'h0000) begin
			left_q <= left_q - 16'h0001;
		end
	end
	assign rawIn = (left_q != 16'h0000) ? level ^ pulseMask : level;
endmodule

`default_nettype wire

/* File: verification/dif_input_filter_test.sv */
`default_nettype none

module dif_input_filter_test import dif_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int MS = 10;
	logic clk = 1'b0, reset_n = 1'b0, pulseGo = 1'b0, cfgError;
	logic cfgWrite = 1'b0, cfgClear = 1'b0, endOfScan = 1'b0;
	logic [GROUP_W-1:0] cfgGroup = 2'h0;
	logic [MS_W-1:0] cfgFilterMs = 4'h0;
	logic [NUM_GROUPS-1:0] groupNormal = 4'hF;
	logic [15:0] level = 16'h0000, pulseMask = 16'h0000;
	logic [15:0] pulseLen = 16'h0000, rawIn, inputImage;
	logic [15:0] imgQ[$];
	logic errQ[$];
	logic scanD = 1'b0, cfgD = 1'b0;
	logic [31:0] seed = 32'hE9D7;
	int fails = 0, total_checks = 0, cycles = 0;
	int tMs[NUM_GROUPS];

	dif_noise_src i_src (.clk(clk), .reset_n(reset_n), .level(level),
		.pulseMask(pulseMask), .pulseLen(pulseLen), .pulseGo(pulseGo),
		.rawIn(rawIn));
	dif_input_filter #(.NUM_INPUTS(16), .TICK_CYCLES_P(MS)) i_dut (
		.clk(clk), .reset_n(reset_n), .rawIn(rawIn), .cfgWrite(cfgWrite),
		.cfgGroup(cfgGroup), .cfgFilterMs(cfgFilterMs), .cfgClear(cfgClear),
		.groupNormal(groupNormal), .endOfScan(endOfScan),
		.inputImage(inputImage), .cfgError(cfgError));

	initial begin
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] xorshift(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		scanD <= endOfScan;
		cfgD <= cfgWrite | cfgClear;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fails++;
			finish_test();
		end
	end

	// results land on the edge that took the request and are read at the next falling edge
	always @(negedge clk) begin
		if (scanD) check("inputImage", inputImage, imgQ.pop_front());
		if (cfgD) check("cfgError", {15'h0000, cfgError},
			{15'h0000, errQ.pop_front()});
	end

	task automatic cfg(int g, int ms, logic clr, logic err);
		cfgWrite <= 1'b1;
		cfgGroup <= g[GROUP_W-1:0];
		cfgFilterMs <= ms[MS_W-1:0];
		cfgClear <= clr;
		errQ.push_back(err);
		@(posedge clk);
		cfgWrite <= 1'b0;
		cfgClear <= 1'b0;
		// idle edge so a following call never re-raises the strobe at once
		@(posedge clk);
	endtask

	task automatic scan(logic [15:0] exp);
		endOfScan <= 1'b1;
		imgQ.push_back(exp);
		@(posedge clk);
		endOfScan <= 1'b0;
	endtask

	// passing glitches are scanned while held, rejected ones after they end
	task automatic glitch(logic [15:0] mask, int len, logic pass);
		pulseMask <= mask;
		pulseLen <= len[15:0];
		pulseGo <= 1'b1;
		@(posedge clk);
		pulseGo <= 1'b0;
		repeat (pass ? len - 2 : len + 2) @(posedge clk);
		scan(pass ? level ^ mask : level);
		repeat (200) @(posedge clk);
	endtask

	task automatic groups();
		logic [15:0] m;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			m = 16'h0003 << (2 * g);
			if (!groupNormal[g] || tMs[g] == 0) begin
				glitch(m, MS, 1'b1);
			end else begin
				glitch(m, MS * tMs[g] + MS, 1'b1);
				glitch(m, MS * (tMs[g] - 2) - 1, 1'b0);
			end
		end
		glitch(16'hFF00, 4 * MS, 1'b1);
		glitch(16'hFF00, MS - 1, 1'b0);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		scan(16'h0000);
		level <= 16'hFFFF;
		repeat (60) @(posedge clk);
		scan(16'hFFFF);
		cfg(0, 1, 1'b0, 1'b1);
		cfg(1, 2, 1'b0, 1'b1);
		cfg(2, 2, 1'b1, 1'b0);
		for (int r = 0; r < 4; r++) begin
			seed = xorshift(seed);
			groupNormal <= (r == 0) ? 4'hF : seed[7:4];
			for (int g = 0; g < NUM_GROUPS; g++) begin
				seed = xorshift(seed);
				tMs[g] = (r == 0) ? g * 5 : int'(seed % 14);
				if (r != 0 && tMs[g] != 0) tMs[g] += 2;
				cfg(g, tMs[g], 1'b0, 1'b0);
			end
			groups();
		end
		groupNormal <= 4'hF;
		cfg(0, 9, 1'b1, 1'b0);
		tMs = '{3, 3, 3, 3};
		groups();
		finish_test();
	end
endmodule

`default_nettype wire
